// ==== hw/ppm_rx_decoder.sv ====
// Reader-to-tag pulse position decoder with its receive FIFO
// Functional notes
// R1: Both pause depths decode the same way
// R2: Reader picks the depth; tag accepts either
// R3: Start of frame selects the coding mode
// R4: 256-slot mode: slot of pause gives byte
// R5: Reader puts pause in slot's second half
// R6: First slot is 00h, last slot is FFh
// R7: 256-slot byte lasts all 256 slots
// R8: 4-slot mode: slot of pause gives bit pair
// R9: Four pairs per byte, first pair lowest
// R10: 4-slot byte spans sixteen slots
// R11: Delimiters are code violations; reserved ones rejected
// R12: Ready again after turnaround from response end
// R13: Wait power-on delay after field appears
// R14: Reader speaks first; tag never sends unprompted
// R15: Same end-of-frame pattern in both modes
// R16: Slot k maps to bit pair value k
// R17: Slot timing counts 256 carrier cycles
`timescale 1ns/1ps

module ppm_rx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];     // Storage words
  logic [PW-1:0]    wr_ptr_reg;      // Next free slot
  logic [PW-1:0]    rd_ptr_reg;      // Head slot
  logic [PW:0]      count_reg;       // Words held
  logic             push;            // Word accepted
  logic             pop;             // Word taken
  logic [PW-1:0]    rd_ptr_next;     // Head after this cycle
  logic [PW:0]      count_next;      // Fill after this cycle

  // Handshakes and next pointers
  always_comb begin
    push        = in_valid_i & in_ready_o;
    pop         = out_valid_o & out_ready_i;
    rd_ptr_next = pop ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
    count_next  = count_reg + (PW+1)'(push) - (PW+1)'(pop);
  end

  // Storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers, fill level and registered flags
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      count_reg   <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= PW'(wr_ptr_reg + 1'b1);
      end
      rd_ptr_reg  <= rd_ptr_next;
      count_reg   <= count_next;
      in_ready_o  <= (count_next != (PW+1)'(DEPTH));
      out_valid_o <= (count_next != '0);
    end
  end

  // Head word is held in a register so the output never glitches
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_data_o <= '0;
    end else if (push && (wr_ptr_reg == rd_ptr_next)) begin
      out_data_o <= in_data_i;  // Written into an otherwise empty queue
    end else begin
      out_data_o <= mem[rd_ptr_next];
    end
  end

endmodule : ppm_rx_fifo

module ppm_rx_decoder #(
  parameter int TURN_CYC   = ppm_rx_pkg::TURN_CYC,
  parameter int FIFO_DEPTH = ppm_rx_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_i,
  // Carrier timebase and field
  input  wire logic                 carrier_tick_i,
  input  wire logic                 field_on_i,
  // Demodulated pauses, one per modulation depth
  input  wire logic                 pause_deep_i,
  input  wire logic                 pause_shallow_i,
  // Response path
  input  wire logic                 tx_done_i,
  // Decoded byte stream
  output logic                      rx_valid_o,
  input  wire logic                 rx_ready_i,
  output ppm_rx_pkg::rx_byte_s      rx_data_o,
  // Status
  output logic                      cmd_ready_o,
  output logic                      in_frame_o,
  output ppm_rx_pkg::coding_mode_e  mode_o,
  output logic                      frame_end_o,
  output logic                      frame_err_o,
  output logic                      sof_reserved_o
);

  // Receiver states
  typedef enum logic [2:0] {rx_off, rx_idle, rx_sof, rx_data} rx_state_e;

  rx_state_e                 state_reg;      // Receiver state
  logic                      pause_prev_reg; // Pause level last cycle
  logic                      pause_rise;     // Start of a pause
  logic [15:0]               cnt_reg;        // Carrier cycles into window
  logic                      second_reg;     // Second SOF pause seen
  logic                      got_pause_reg;  // Pause seen in this window
  logic [15:0]               first_pos_reg;  // Where that pause fell
  logic [7:0]                sym_reg;        // Its slot value
  logic [1:0]                pair_idx_reg;   // Next bit pair position
  logic [7:0]                shift_reg;      // Byte under assembly
  logic                      first_reg;      // No byte pushed yet
  logic                      win_end;        // Last carrier of window
  logic [12:0]               wait_cnt_reg;   // Readiness countdown
  logic                      waiting_reg;    // Readiness delay running
  logic                      push_reg;       // Byte offered to FIFO
  ppm_rx_pkg::rx_byte_s      push_data_reg;  // Byte offered
  logic                      fifo_in_ready;  // FIFO can take a byte

  // Spacing check with tolerance, used for every delimiter
  function automatic logic near(input logic [15:0] v, input logic [15:0] target);
    logic [15:0] d;
    d = (v > target) ? 16'(v - target) : 16'(target - v);
    return d <= ppm_rx_pkg::GAP_TOL;
  endfunction : near

  // Slot index of a carrier count within its window
  function automatic logic [7:0] slot_of(input logic [15:0] c,
                                         input ppm_rx_pkg::coding_mode_e m);
    logic [7:0] s;
    s = (m == ppm_rx_pkg::mode_1of256) ? c[15:8] : {6'h00, c[9:8]};  // see R17
    return s;
  endfunction : slot_of

  // Both depths give the same pause level
  always_comb begin
    pause_rise = (pause_deep_i | pause_shallow_i) & ~pause_prev_reg;  // see R1 see R2
  end

  // Window end depends on the mode the frame opened with
  always_comb begin
    if (mode_o == ppm_rx_pkg::mode_1of256) begin
      win_end = carrier_tick_i && (cnt_reg == ppm_rx_pkg::WIN_LAST_1OF256);  // see R7
    end else begin
      win_end = carrier_tick_i && (cnt_reg == ppm_rx_pkg::WIN_LAST_1OF4);  // see R10
    end
  end

  // Pause edge history
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pause_prev_reg <= 1'b0;
    end else begin
      pause_prev_reg <= pause_deep_i | pause_shallow_i;
    end
  end

  // Power-on and turnaround delays share one countdown
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wait_cnt_reg <= 13'(ppm_rx_pkg::POR_CYC - 1);
      waiting_reg  <= 1'b1;
      cmd_ready_o  <= 1'b0;
    end else if (!field_on_i) begin
      // No field means no power: restart the power-on delay
      wait_cnt_reg <= 13'(ppm_rx_pkg::POR_CYC - 1);  // see R13
      waiting_reg  <= 1'b1;
      cmd_ready_o  <= 1'b0;
    end else if (tx_done_i) begin
      wait_cnt_reg <= 13'(TURN_CYC - 1);  // see R12
      waiting_reg  <= 1'b1;
      cmd_ready_o  <= 1'b0;
    end else if (waiting_reg) begin
      if (wait_cnt_reg == '0) begin
        waiting_reg <= 1'b0;
        cmd_ready_o <= 1'b1;  // see R13 see R12
      end else begin
        wait_cnt_reg <= wait_cnt_reg - 13'h0001;
      end
    end
  end

  // Frame decoder: delimiters, slot timing and byte assembly
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg      <= rx_off;
      cnt_reg        <= '0;
      second_reg     <= 1'b0;
      got_pause_reg  <= 1'b0;
      first_pos_reg  <= '0;
      sym_reg        <= '0;
      pair_idx_reg   <= '0;
      shift_reg      <= '0;
      first_reg      <= 1'b1;
      mode_o         <= ppm_rx_pkg::mode_1of4;
      in_frame_o     <= 1'b0;
      frame_end_o    <= 1'b0;
      frame_err_o    <= 1'b0;
      sof_reserved_o <= 1'b0;
      push_reg       <= 1'b0;
      push_data_reg  <= '0;
    end else begin
      // Pulses last one cycle
      frame_end_o    <= 1'b0;
      frame_err_o    <= 1'b0;
      sof_reserved_o <= 1'b0;
      push_reg       <= 1'b0;
      if (carrier_tick_i) begin
        cnt_reg <= cnt_reg + 16'h0001;  // see R17
      end
      if (!field_on_i) begin
        state_reg  <= rx_off;
        in_frame_o <= 1'b0;
      end else begin
        case (state_reg)
          rx_off: begin
            state_reg <= rx_idle;
          end
          // Reader opens every exchange; frames wait for readiness
          rx_idle: begin
            if (pause_rise && cmd_ready_o) begin  // see R14
              state_reg  <= rx_sof;
              cnt_reg    <= '0;
              second_reg <= 1'b0;
              in_frame_o <= 1'b1;
            end
          end
          // Spacing of the second pause names the mode
          rx_sof: begin
            if (pause_rise) begin
              if (!second_reg && near(cnt_reg, ppm_rx_pkg::SOF_GAP_1OF256)) begin
                mode_o     <= ppm_rx_pkg::mode_1of256;  // see R3
                second_reg <= 1'b1;
              end else if (!second_reg && near(cnt_reg, ppm_rx_pkg::SOF_GAP_1OF4)) begin
                mode_o     <= ppm_rx_pkg::mode_1of4;  // see R3
                second_reg <= 1'b1;
              end else begin
                // Unknown delimiter shape is reserved: drop the frame
                sof_reserved_o <= 1'b1;  // see R11
                frame_err_o    <= 1'b1;
                in_frame_o     <= 1'b0;
                state_reg      <= rx_idle;
              end
            end else if (carrier_tick_i && (cnt_reg == ppm_rx_pkg::SOF_LEN - 16'h0001)) begin
              if (second_reg) begin
                state_reg     <= rx_data;
                cnt_reg       <= '0;
                got_pause_reg <= 1'b0;
                pair_idx_reg  <= '0;
                shift_reg     <= '0;
                first_reg     <= 1'b1;
              end else begin
                sof_reserved_o <= 1'b1;  // see R11
                frame_err_o    <= 1'b1;
                in_frame_o     <= 1'b0;
                state_reg      <= rx_idle;
              end
            end
          end
          // One pause per window; a second one is the end delimiter
          rx_data: begin
            if (pause_rise && !got_pause_reg) begin
              got_pause_reg <= 1'b1;
              first_pos_reg <= cnt_reg;
              sym_reg       <= slot_of(cnt_reg, mode_o);  // see R4 see R6 see R8 see R16
            end else if (pause_rise) begin
              // Same check in either mode
              if (near(16'(cnt_reg - first_pos_reg), ppm_rx_pkg::EOF_GAP)
                  && (pair_idx_reg == 2'b00)) begin
                frame_end_o <= 1'b1;  // see R11 see R15
              end else begin
                frame_err_o <= 1'b1;  // Bad violation or half-built byte
              end
              in_frame_o <= 1'b0;
              state_reg  <= rx_idle;
            end else if (win_end) begin
              cnt_reg       <= '0;
              got_pause_reg <= 1'b0;
              if (!got_pause_reg) begin
                // Silent window: reader stopped without a delimiter
                frame_err_o <= 1'b1;
                in_frame_o  <= 1'b0;
                state_reg   <= rx_idle;
              end else if (mode_o == ppm_rx_pkg::mode_1of256) begin
                if (fifo_in_ready) begin
                  push_reg            <= 1'b1;  // see R4
                  push_data_reg.data  <= sym_reg;
                  push_data_reg.mode  <= mode_o;
                  push_data_reg.first <= first_reg;
                  first_reg           <= 1'b0;
                end else begin
                  // Reader cannot be stalled, so a full queue loses the frame
                  frame_err_o <= 1'b1;
                  in_frame_o  <= 1'b0;
                  state_reg   <= rx_idle;
                end
              end else begin
                shift_reg[2*pair_idx_reg +: 2] <= sym_reg[1:0];  // see R9
                pair_idx_reg                   <= pair_idx_reg + 2'b01;
                if (pair_idx_reg == 2'b11) begin
                  if (fifo_in_ready) begin
                    push_reg            <= 1'b1;  // see R9 see R10
                    push_data_reg.data  <= {sym_reg[1:0], shift_reg[5:0]};
                    push_data_reg.mode  <= mode_o;
                    push_data_reg.first <= first_reg;
                    first_reg           <= 1'b0;
                  end else begin
                    frame_err_o <= 1'b1;
                    in_frame_o  <= 1'b0;
                    state_reg   <= rx_idle;
                  end
                end
              end
            end
          end
          default: begin
            state_reg  <= rx_off;
            in_frame_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // Receive queue between decoder and command logic
  ppm_rx_fifo #(
    .WIDTH ($bits(ppm_rx_pkg::rx_byte_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (ref_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (push_reg),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_data_reg),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o)
  );

endmodule : ppm_rx_decoder

// ==== hw/ppm_rx_pkg.sv ====
// Shared constants, types and timing for the reader-to-tag pulse position decoder
package ppm_rx_pkg;

  // Clock period of ref_clk_i
  localparam int CLK_PERIOD_NS = 50;

  // Power-on delay after the field appears, 0.1 ms
  localparam int POR_TIME_NS = 100000;
  // Turnaround after a response frame, 311.5 us
  localparam int TURN_TIME_NS = 311500;

  // Least times round up to whole clock cycles
  localparam int POR_CYC  = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_CYC = (TURN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Carrier cycles per time slot
  localparam int SLOT_CARRIERS = 256;
  // Slots per symbol window in each coding mode
  localparam int SLOTS_1OF4    = 4;
  localparam int SLOTS_1OF256  = 256;
  // Last carrier count of a symbol window
  localparam logic [15:0] WIN_LAST_1OF4   = 16'((SLOTS_1OF4 * SLOT_CARRIERS) - 1);
  localparam logic [15:0] WIN_LAST_1OF256 = 16'((SLOTS_1OF256 * SLOT_CARRIERS) - 1);

  // Delimiter timing in carrier cycles, measured from the first pause
  localparam logic [15:0] SOF_GAP_1OF256 = 16'h0300;
  localparam logic [15:0] SOF_GAP_1OF4   = 16'h0200;
  localparam logic [15:0] SOF_LEN        = 16'h0400;
  localparam logic [15:0] EOF_GAP        = 16'h0100;
  // Tolerance on a delimiter spacing, carrier cycles
  localparam logic [15:0] GAP_TOL        = 16'h0020;

  // Receive FIFO shape
  localparam int FIFO_DEPTH = 8;

  // Coding mode picked by the start of frame
  typedef enum logic {mode_1of4, mode_1of256} coding_mode_e;

  // One decoded byte as it travels through the FIFO
  typedef struct packed {
    logic         first;  // First byte of its frame
    coding_mode_e mode;   // Mode it was received in
    logic [7:0]   data;   // Byte value
  } rx_byte_s;

endpackage : ppm_rx_pkg

// ==== verif/ppm_rx_decoder_sva.sv ====
// Port-level assertions for the pulse position decoder
`timescale 1ns/1ps
module ppm_rx_decoder_sva #(
  parameter int TURN_CYC   = 50,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic                     ref_clk_i,
  input wire logic                     reset_i,
  // Inputs watched
  input wire logic                     field_on_i,
  input wire logic                     tx_done_i,
  input wire logic                     rx_ready_i,
  // Outputs watched
  input wire logic                     rx_valid_o,
  input wire ppm_rx_pkg::rx_byte_s     rx_data_o,
  input wire logic                     cmd_ready_o,
  input wire logic                     in_frame_o,
  input wire ppm_rx_pkg::coding_mode_e mode_o,
  input wire logic                     frame_end_o,
  input wire logic                     frame_err_o,
  input wire logic                     sof_reserved_o
);
  logic [15:0] field_cnt_reg;  // Field cycles since reset or loss
  logic [15:0] turn_cnt_reg;   // Cycles since a response ended
  logic        turn_seen_reg;  // A response ended since reset

  // Field age, saturating so a long run never wraps
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) field_cnt_reg <= 16'h0000;
    else if (!field_on_i) field_cnt_reg <= 16'h0000;
    else if (field_cnt_reg != 16'hffff) field_cnt_reg <= field_cnt_reg + 16'h0001;
  end
  // Turnaround age, also saturating
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) turn_cnt_reg <= 16'h0000;
    else if (tx_done_i) turn_cnt_reg <= 16'h0000;
    else if (turn_cnt_reg != 16'hffff) turn_cnt_reg <= turn_cnt_reg + 16'h0001;
  end
  // Remembers that a turnaround has begun
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) turn_seen_reg <= 1'b0;
    else if (tx_done_i) turn_seen_reg <= 1'b1;
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // End pulse stands alone for one cycle
  sequence end_alone_s;
    !frame_err_o ##1 !frame_end_o;
  endsequence
  // Frame flag drops shortly after a verdict
  sequence leave_frame_s;
    ##[1:2] !in_frame_o;
  endsequence

  por_wait_a: assert property (
    $rose(cmd_ready_o) |-> field_cnt_reg >= 16'(ppm_rx_pkg::POR_CYC))
    else $error("Command ready rose before the power-on delay");
  field_loss_a: assert property (!field_on_i |=> !cmd_ready_o)
    else $error("Command ready high without field");
  turn_wait_a: assert property (
    $rose(cmd_ready_o) |-> !turn_seen_reg || turn_cnt_reg >= 16'(TURN_CYC))
    else $error("Command ready rose before turnaround ended");
  turn_drop_a: assert property (tx_done_i |-> ##2 !cmd_ready_o)
    else $error("Command ready held during turnaround");
  reserved_err_a: assert property (sof_reserved_o |-> frame_err_o)
    else $error("Reserved start without frame error");
  end_pulse_a: assert property (frame_end_o |-> end_alone_s)
    else $error("End pulse overlapped an error or lasted too long");
  frame_leave_a: assert property ((frame_end_o || frame_err_o) |-> leave_frame_s)
    else $error("Frame flag stayed after a frame verdict");
  mode_sof_a: assert property ($changed(mode_o) |-> ##[0:1] in_frame_o)
    else $error("Mode changed outside a start of frame");
  fifo_hold_a: assert property (
    rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
    else $error("Stalled byte changed or vanished");
endmodule : ppm_rx_decoder_sva

bind ppm_rx_decoder ppm_rx_decoder_sva #(.TURN_CYC(TURN_CYC), .FIFO_DEPTH(FIFO_DEPTH)) u_sva (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .field_on_i(field_on_i), .tx_done_i(tx_done_i),
  .rx_ready_i(rx_ready_i), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
  .cmd_ready_o(cmd_ready_o), .in_frame_o(in_frame_o), .mode_o(mode_o),
  .frame_end_o(frame_end_o), .frame_err_o(frame_err_o), .sof_reserved_o(sof_reserved_o));

// ==== verif/reader_to_tag_ppm_decoder_tb.sv ====
// Self-checking bench for the reader-to-tag pulse position decoder
`timescale 1ns/1ps
module reader_to_tag_ppm_decoder_tb;
  localparam int TURN  = 50;  // Short turnaround keeps the run brief
  localparam int DEPTH = 2;   // Short FIFO so an overflow fits the run
  localparam int GAP4  = int'(ppm_rx_pkg::SOF_GAP_1OF4);
  logic ref_clk_i, tick, deep, shallow, rx_valid, cmd_ready, in_frame, f_end, f_err, f_rsv;
  logic reset_i = 1'b1, field_on = 1'b1, tx_done = 1'b0, rx_ready = 1'b1, ready_en = 1'b1;
  logic                     stall = 1'b0;  // Random consumer stalls when set
  ppm_rx_pkg::rx_byte_s     rx_data;       // Byte at the FIFO head
  ppm_rx_pkg::coding_mode_e mode;          // Mode of the last frame
  ppm_rx_pkg::rx_byte_s     exp_q[$];      // Bytes still owed, oldest first
  int fail_count = 0, n_compared = 0, n_end = 0, n_err = 0, n_rsv = 0;
  int e_end = 0, e_err = 0, e_rsv = 0;     // Pulse tallies expected so far

  // 20 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  vicinity_reader_model rdr (.ref_clk_i(ref_clk_i), .carrier_tick_o(tick), .pause_deep_o(deep),
                             .pause_shallow_o(shallow));
  ppm_rx_decoder #(.TURN_CYC(TURN), .FIFO_DEPTH(DEPTH)) DUT (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .carrier_tick_i(tick), .field_on_i(field_on),
    .pause_deep_i(deep), .pause_shallow_i(shallow), .tx_done_i(tx_done), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready), .rx_data_o(rx_data), .cmd_ready_o(cmd_ready), .in_frame_o(in_frame),
    .mode_o(mode), .frame_end_o(f_end), .frame_err_o(f_err), .sof_reserved_o(f_rsv));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize;
    $display("Compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  // Out of patience: count it and close the run
  task automatic give_up(input string nm);
    fail_count++;
    $display("MISMATCH %s expected done seen timeout", nm);
    summarize();
  endtask : give_up
  // Pulse tallies must reach the expected values, and no extra pulse follows
  task automatic await_status(input int de, input int dr, input int ds);
    int n;
    e_end += de;
    e_err += dr;
    e_rsv += ds;
    for (n = 0; n < 5000 && !(n_end == e_end && n_err == e_err && n_rsv == e_rsv); n++)
      @(posedge ref_clk_i);
    if (n >= 5000) give_up("status_pulses");
    else begin
      repeat (8) @(posedge ref_clk_i);
      chk("status_tally", {4'(e_end), 4'(e_err), 4'(e_rsv)}, {4'(n_end), 4'(n_err), 4'(n_rsv)});
      chk("in_frame_end", 16'h0000, 16'(in_frame));
    end
  endtask : await_status
  // Ready must come back exactly lo cycles on
  task automatic wait_ready(input int lo);
    int n;
    for (n = 0; n < lo + 200 && cmd_ready !== 1'b1; n++) @(posedge ref_clk_i);
    if (n >= lo + 200) give_up("cmd_ready");
    else chk("ready_delay", 16'(lo), 16'(n));
  endtask : wait_ready
  task automatic note(input logic f, input ppm_rx_pkg::coding_mode_e m, input logic [7:0] v);
    exp_q.push_back('{first: f, mode: m, data: v});
  endtask : note
  // One short-mode byte as four pairs, lowest first, random depth
  task automatic send4(input int i0, input logic [7:0] v);
    for (int k = 0; k < 4; k++) rdr.sym(i0 + k, int'(v[2*k +: 2]), 1'b0, 1'($urandom));
  endtask : send4
  task automatic done(input string nm);
    repeat (40) @(posedge ref_clk_i);
    $display("%s done", nm);
  endtask : done

  // Oldest note against each byte taken, pulse tallies, consumer drive
  always @(posedge ref_clk_i) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (exp_q.size() == 0) chk("spare_byte", 16'h0000, 16'h0001);
      else chk("rx_byte", 16'(exp_q.pop_front()), 16'(rx_data));
    end
    n_end += int'(f_end === 1'b1);
    n_err += int'(f_err === 1'b1);
    n_rsv += int'(f_rsv === 1'b1);
    rx_ready <= stall ? 1'($urandom) : ready_en;
  end

  // Main sequence
  initial begin
    logic [7:0] v;
    void'($urandom(59));
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    wait_ready(ppm_rx_pkg::POR_CYC + 1);
    done("power_on");
    // Long mode: one byte, then the end pattern
    v = 8'($urandom);
    note(1'b1, ppm_rx_pkg::mode_1of256, v);
    rdr.sof(int'(ppm_rx_pkg::SOF_GAP_1OF256), 1'b1);
    chk("in_frame_sof", 16'h0001, 16'(in_frame));
    rdr.sym(0, int'(v), 1'b1, 1'b0);
    rdr.eof(1, 1'b1, 1'b1);
    await_status(1, 0, 0);
    chk("mode", 16'(ppm_rx_pkg::mode_1of256), 16'(mode));
    done("long_mode");
    // Turnaround after a response
    tx_done <= 1'b1;
    @(posedge ref_clk_i);
    tx_done <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    wait_ready(TURN - 2);
    done("turnaround");
    // Short mode into a stalled consumer until the FIFO refuses
    ready_en <= 1'b0;
    rdr.sof(GAP4, 1'b0);
    for (int i = 0; i <= DEPTH; i++) begin
      v = 8'($urandom);
      if (i < DEPTH) note(i == 0, ppm_rx_pkg::mode_1of4, v);
      send4(4 * i, v);
    end
    await_status(0, 1, 0);
    ready_en <= 1'b1;
    done("overflow");
    // Short mode with random stalls, then the shared end pattern
    stall <= 1'b1;
    rdr.gappy <= 1'b1;  // Ragged carrier for this frame
    v = 8'($urandom);
    note(1'b1, ppm_rx_pkg::mode_1of4, v);
    rdr.sof(GAP4, 1'b1);
    send4(0, v);
    rdr.eof(4, 1'b0, 1'b0);
    await_status(1, 0, 0);
    chk("mode", 16'(ppm_rx_pkg::mode_1of4), 16'(mode));
    stall <= 1'b0;
    rdr.gappy <= 1'b0;
    done("short_mode");
    // End pattern with half a byte pending
    rdr.sof(GAP4, 1'b0);
    rdr.sym(0, 3, 1'b0, 1'b1);
    rdr.sym(1, 0, 1'b0, 1'b0);
    rdr.eof(2, 1'b0, 1'b1);
    await_status(0, 1, 0);
    done("partial_byte");
    // Start spacing that names no mode
    rdr.sof(GAP4 + 128, 1'b1);
    await_status(0, 1, 1);
    done("reserved_start");
    // Field loss restarts the power-on wait
    field_on <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    chk("ready_without_field", 16'h0000, 16'(cmd_ready));
    field_on <= 1'b1;
    wait_ready(ppm_rx_pkg::POR_CYC + 1);
    done("field_loss");
    chk("bytes_left", 16'h0000, 16'(exp_q.size()));
    summarize();
  end
endmodule : reader_to_tag_ppm_decoder_tb

// ==== verif/vicinity_reader_model.sv ====
// Behavioural reader that places pauses on the tag's link
`timescale 1ns/1ps
module vicinity_reader_model (
  // Clock
  input  wire logic ref_clk_i,
  // Link toward the tag
  output logic      carrier_tick_o,
  output logic      pause_deep_o,
  output logic      pause_shallow_o
);
  localparam int SOF  = int'(ppm_rx_pkg::SOF_LEN);  // Start of frame length
  localparam int SLOT = ppm_rx_pkg::SLOT_CARRIERS;  // Carriers per slot
  int now  = 0;  // Carrier cycles elapsed
  int base = 0;  // Carrier count at the frame's first pause
  bit gappy = 1'b0;  // Drop random carrier ticks when set
  // Carrier enable; gaps make the tag count ticks rather than clocks
  always @(posedge ref_clk_i) carrier_tick_o <= !gappy || ($urandom % 8 != 0);
  initial pause_deep_o = 1'b0;
  initial pause_shallow_o = 1'b0;
  // Carrier count
  always @(posedge ref_clk_i) if (carrier_tick_o) now <= now + 1;
  // One pause t carriers after frame start, depth picked by the reader
  task automatic pause_at(input int t, input bit deep);
    while (now < base + t) @(posedge ref_clk_i);
    if (deep) pause_deep_o <= 1'b1;
    else pause_shallow_o <= 1'b1;
    repeat (16) @(posedge ref_clk_i);
    pause_deep_o    <= 1'b0;
    pause_shallow_o <= 1'b0;
  endtask : pause_at
  // Start of frame: pause spacing names the coding mode
  task automatic sof(input int gap, input bit deep);
    base = now;
    pause_at(0, deep);
    pause_at(gap, deep);
  endtask : sof
  // Symbol idx in slot k, late in the slot; windows are fixed length
  task automatic sym(input int idx, input int k, input bit m256, input bit deep);
    pause_at(SOF + idx * SLOT * (m256 ? ppm_rx_pkg::SLOTS_1OF256 : ppm_rx_pkg::SLOTS_1OF4)
             + SLOT * k + SLOT / 2 + 32, deep);
  endtask : sym
  // End of frame: same pause pair in either mode
  task automatic eof(input int idx, input bit m256, input bit deep);
    sym(idx, 0, m256, deep);
    sym(idx, 1, m256, deep);
  endtask : eof
endmodule : vicinity_reader_model
